// file: shared/lpm_cfg.svh
// Offsets-free constant set: timing counts and event routing codes
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// ****************************************************************
// Clock and timer timing
// ****************************************************************
`define LPM_CLK_PERIOD_NS 5
`define LPM_TIMER_TICK_NS 1000000
`define LPM_TICK_CYCLES (`LPM_TIMER_TICK_NS / `LPM_CLK_PERIOD_NS)
`define LPM_WAKE_PERIOD_MS 60000
`define LPM_TIMER_W 16
`define LPM_TIMER_RELOAD 16'(`LPM_WAKE_PERIOD_MS - 1)
`define LPM_MIN_PER_HOUR 60
`define LPM_HOUR_W 6

// ****************************************************************
// Converter start trigger source select codes
// ****************************************************************
`define LPM_ROUTE_SNOOZE 1'b0
`define LPM_ROUTE_TIMER 1'b1

`endif

// file: shared/lpm_pkg.sv
// Types shared by the power mode controller
package lpm_pkg;

  // ****************************************************************
  // Operating modes, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    M_NORMAL = 4'h1,
    M_SLEEP = 4'h2,
    M_STANDBY = 4'h4,
    M_SNOOZE = 4'h8
  } mode_t;

endpackage : lpm_pkg

// file: core/periodic_wake_timer.sv
// Periodic wake timer: 16-bit down counter on a millisecond prescaler
`timescale 1ns/1ps
`include "lpm_cfg.svh"

module periodic_wake_timer #(
  parameter logic [31:0] TICK_CYCLES = `LPM_TICK_CYCLES,
  parameter logic [15:0] RELOAD = `LPM_TIMER_RELOAD
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  output logic timer_underflow_event
);

  logic [31:0] pre;
  logic [15:0] count;
  logic next_uf;
  logic [31:0] next_pre;
  logic [15:0] next_count;

  // ****************************************************************
  // Prescaler and down counter
  // ****************************************************************
  // Keeps running in every mode, it moves Standby into Snooze and paces the hourly alarm
  always_comb begin
    next_pre = pre;
    next_count = count;
    next_uf = 1'b0;
    if (ce) begin
      if (pre == TICK_CYCLES - 32'h1) begin
        next_pre = 32'h0;
        if (count == 16'h0) begin
          next_count = RELOAD; // One underflow per wake period
          next_uf = 1'b1;
        end else begin
          next_count = count - 16'h1;
        end
      end else begin
        next_pre = pre + 32'h1;
      end
    end else begin
      next_uf = timer_underflow_event;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre <= 32'h0;
      count <= RELOAD;
      timer_underflow_event <= 1'b0;
    end else begin
      pre <= next_pre;
      count <= next_count;
      timer_underflow_event <= next_uf;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_uf_pulse;
    @(posedge mclk) disable iff (rst)
      (ce && timer_underflow_event) |=> !timer_underflow_event;
  endproperty
  a_uf_pulse: assert property (p_uf_pulse)
    else $error("timer underflow longer than one cycle");

endmodule : periodic_wake_timer

// file: core/low_power_mode_sequencer.sv
// Power mode controller with event router and hourly calendar alarm
//
// How it works
// - Sleep halts CPU, keeps registers, peripherals run.
// - Any reset or interrupt ends Sleep.
// - Standby stops CPU, peripherals and oscillators.
// - Standby retains registers, SRAM, peripherals, port states.
// - Snooze entered only from Standby by request.
// - Snooze interrupts go to Normal or Standby.
// - Timer underflow moves Standby into Snooze.
// - Transfer completion returns Snooze to Standby.
// - Wake lines or alarm go to Normal.
// - Router picks Snooze request or underflow for conversion.
// - Compare and judgment events drive ports high.
// - Wake timer underflows once per minute.
// - Calendar alarm once per hour cancels low power.
`timescale 1ns/1ps
`include "lpm_cfg.svh"

module low_power_mode_sequencer #(
  parameter logic [31:0] TICK_CYCLES = `LPM_TICK_CYCLES,
  parameter logic [15:0] TIMER_RELOAD = `LPM_TIMER_RELOAD,
  parameter logic [5:0] MIN_PER_HOUR = 6'(`LPM_MIN_PER_HOUR)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sleep_req,
  input wire logic standby_req,
  input wire logic irq_any,
  input wire logic ext_wake_line_a,
  input wire logic ext_wake_line_b,
  input wire logic transfer_done_event,
  input wire logic route_sel,
  input wire logic adc_compare_match,
  input wire logic judgment_event,
  input wire logic judge_clear,
  output lpm_pkg::mode_t mode,
  output logic cpu_halt,
  output logic periph_run,
  output logic snooze_periph_run,
  output logic osc_run,
  output logic state_hold,
  output logic calendar_alarm_event,
  output logic adc_start_trig,
  output logic port_out_cmp,
  output logic port_out_judge
);

  // ****************************************************************
  // Wake pin synchronisers
  // ****************************************************************
  logic [2:0] sync_a, sync_b;
  logic level_a, level_b;
  logic next_level_a, next_level_b;
  logic rise_a, rise_b;

  // A change counts once the second and third stages agree
  always_comb begin
    next_level_a = level_a;
    next_level_b = level_b;
    if (ce && sync_a[1] == sync_a[2]) begin
      next_level_a = sync_a[2];
    end
    if (ce && sync_b[1] == sync_b[2]) begin
      next_level_b = sync_b[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      level_a <= 1'b0;
      level_b <= 1'b0;
    end else if (ce) begin
      sync_a <= {sync_a[1:0], ext_wake_line_a};
      sync_b <= {sync_b[1:0], ext_wake_line_b};
      level_a <= next_level_a;
      level_b <= next_level_b;
    end
  end

  // Rising edge of the filtered level wakes the device
  assign rise_a = next_level_a && !level_a;
  assign rise_b = next_level_b && !level_b;

  // ****************************************************************
  // Wake timer and hourly calendar
  // ****************************************************************
  logic timer_underflow_event;
  logic [5:0] minutes, next_minutes;
  logic next_alarm;

  periodic_wake_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .RELOAD(TIMER_RELOAD)
  ) u_timer (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .timer_underflow_event(timer_underflow_event)
  );

  // Calendar counts minute underflows and alarms on the hour
  always_comb begin
    next_minutes = minutes;
    next_alarm = 1'b0;
    if (ce && timer_underflow_event) begin
      if (minutes == MIN_PER_HOUR - 6'h1) begin
        next_minutes = 6'h0;
        next_alarm = 1'b1;
      end else begin
        next_minutes = minutes + 6'h1;
      end
    end
    if (!ce) begin
      next_alarm = calendar_alarm_event;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      minutes <= 6'h0;
      calendar_alarm_event <= 1'b0;
    end else begin
      minutes <= next_minutes;
      calendar_alarm_event <= next_alarm;
    end
  end

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  logic wake;
  lpm_pkg::mode_t next_mode;
  logic snooze_request;

  // Wake lines and alarm outrank the snooze request and snooze end
  assign wake = rise_a || rise_b || calendar_alarm_event;

  always_comb begin
    next_mode = mode;
    snooze_request = 1'b0;
    if (ce) begin
      unique case (mode)
        lpm_pkg::M_NORMAL: begin
          if (standby_req) begin
            next_mode = lpm_pkg::M_STANDBY;
          end else if (sleep_req) begin
            next_mode = lpm_pkg::M_SLEEP;
          end
        end
        lpm_pkg::M_SLEEP: begin
          if (irq_any || wake) begin
            next_mode = lpm_pkg::M_NORMAL;
          end
        end
        lpm_pkg::M_STANDBY: begin
          if (wake) begin
            next_mode = lpm_pkg::M_NORMAL;
          end else if (timer_underflow_event) begin
            next_mode = lpm_pkg::M_SNOOZE;
            snooze_request = 1'b1;
          end
        end
        lpm_pkg::M_SNOOZE: begin
          if (wake) begin
            next_mode = lpm_pkg::M_NORMAL;
          end else if (transfer_done_event) begin
            next_mode = lpm_pkg::M_STANDBY;
          end
        end
      endcase
    end
  end

  // Mode outputs follow the next mode so they line up with mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= lpm_pkg::M_NORMAL;
      cpu_halt <= 1'b0;
      periph_run <= 1'b1;
      snooze_periph_run <= 1'b0;
      osc_run <= 1'b1;
      state_hold <= 1'b0;
    end else begin
      mode <= next_mode;
      cpu_halt <= next_mode != lpm_pkg::M_NORMAL;
      periph_run <= next_mode[0] || next_mode[1];
      snooze_periph_run <= next_mode == lpm_pkg::M_SNOOZE;
      osc_run <= !next_mode[2];
      state_hold <= next_mode[2] || next_mode[3];
    end
  end

  // ****************************************************************
  // Event router
  // ****************************************************************
  logic next_start, next_cmp, next_judge;

  // Judgment ports stay high until cleared, a set beats the clear
  always_comb begin
    next_start = adc_start_trig;
    next_cmp = port_out_cmp;
    next_judge = port_out_judge;
    if (ce) begin
      next_start = (route_sel == `LPM_ROUTE_TIMER) ? timer_underflow_event
                                                   : snooze_request;
      if (judge_clear) begin
        next_cmp = 1'b0;
        next_judge = 1'b0;
      end
      if (adc_compare_match) begin
        next_cmp = 1'b1;
      end
      if (judgment_event) begin
        next_judge = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      adc_start_trig <= 1'b0;
      port_out_cmp <= 1'b0;
      port_out_judge <= 1'b0;
    end else begin
      adc_start_trig <= next_start;
      port_out_cmp <= next_cmp;
      port_out_judge <= next_judge;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_sleep_state;
    mode == lpm_pkg::M_SLEEP |-> cpu_halt && periph_run && !state_hold;
  endproperty
  a_sleep_state: assert property (p_sleep_state) else $error("sleep outputs wrong");
  property p_sleep_exit;
    ce && mode == lpm_pkg::M_SLEEP && irq_any |=> mode == lpm_pkg::M_NORMAL;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep kept on interrupt");
  property p_standby_state;
    mode == lpm_pkg::M_STANDBY |-> cpu_halt && !periph_run && !osc_run && state_hold;
  endproperty
  a_standby_state: assert property (p_standby_state)
    else $error("standby outputs wrong");
  property p_snooze_source;
    $rose(mode == lpm_pkg::M_SNOOZE) |-> $past(mode) == lpm_pkg::M_STANDBY
      && $past(timer_underflow_event);
  endproperty
  a_snooze_source: assert property (p_snooze_source)
    else $error("snooze entered from wrong mode");
  // Judged on the next cycle only, a later underflow may reopen Snooze
  property p_snooze_end;
    ce && mode == lpm_pkg::M_SNOOZE && transfer_done_event && !wake
      |=> mode == lpm_pkg::M_STANDBY && !snooze_periph_run;
  endproperty
  a_snooze_end: assert property (p_snooze_end) else $error("snooze end not honoured");
  property p_wake;
    ce && (mode[2] || mode[3]) && wake |=> mode == lpm_pkg::M_NORMAL && !cpu_halt;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not reach normal");
  property p_route;
    ce && route_sel && timer_underflow_event |=> adc_start_trig;
  endproperty
  a_route: assert property (p_route) else $error("conversion start not routed");
  property p_ports;
    ce && adc_compare_match && judgment_event |=> port_out_cmp && port_out_judge;
  endproperty
  a_ports: assert property (p_ports) else $error("judgment port not driven high");
  property p_alarm;
    calendar_alarm_event && ce |-> $past(timer_underflow_event) && minutes == 6'h0;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm off the hour");
  property p_reset;
    disable iff (1'b0) rst |=> mode == lpm_pkg::M_NORMAL && !adc_start_trig;
  endproperty
  a_reset: assert property (p_reset) else $error("reset mode not normal");

  c_snooze: cover property (mode == lpm_pkg::M_SNOOZE ##1 mode == lpm_pkg::M_STANDBY);
  c_alarm_wake: cover property ((mode[2] || mode[3]) && calendar_alarm_event);
  c_line_wake: cover property ((mode[2] || mode[3]) && (rise_a || rise_b));
  c_sleep: cover property (mode == lpm_pkg::M_SLEEP ##1 mode == lpm_pkg::M_NORMAL);

endmodule : low_power_mode_sequencer

// file: verification/transfer_ctrl_model.sv
// Transfer controller model: ends each Snooze after a chosen delay
`timescale 1ns/1ps

module transfer_ctrl_model (
  input wire logic mclk,
  input wire logic rst,
  input wire lpm_pkg::mode_t mode,
  input wire logic [7:0] delay,
  output logic transfer_done_event
);
  logic [7:0] cnt;

  initial transfer_done_event = 1'b0;

  // Count Snooze cycles; one completion pulse when the count reaches delay
  always @(posedge mclk) begin
    transfer_done_event <= 1'b0;
    if (rst || mode !== lpm_pkg::M_SNOOZE) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
      if (cnt == delay) transfer_done_event <= 1'b1;
    end
  end
endmodule : transfer_ctrl_model

// file: verification/low_power_mode_sequencer_tb_top.sv
// Self-checking bench for the low power mode sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module low_power_mode_sequencer_tb_top;
  localparam int P = 64;
  localparam int HOUR = 4;
  logic mclk = 1'b0, rst = 1'b1, sleep_req = 1'b0, standby_req = 1'b0, irq_any = 1'b0;
  logic ext_wake_line_a = 1'b0, ext_wake_line_b = 1'b0, route_sel = 1'b1;
  logic adc_compare_match = 1'b0, judgment_event = 1'b0, judge_clear = 1'b0;
  logic cpu_halt, periph_run, snooze_periph_run, osc_run, state_hold, calendar_alarm_event;
  logic adc_start_trig, port_out_cmp, port_out_judge, transfer_done_event, exp_cmp, exp_judge;
  logic [7:0] delay = 8'h03;
  lpm_pkg::mode_t mode, prev, want;
  lpm_pkg::mode_t expq[$];
  int errors = 0, n_compared = 0, cyc = 0, n_trig = 0, last_trig = -1, last_alm = -1, k;
  int seed = 32'hbcc0;
  bit r0_seen = 1'b0;

  // Short counts keep the minute and the hour within a brief run
  low_power_mode_sequencer #(.TICK_CYCLES(32'h2), .TIMER_RELOAD(16'h1f), .MIN_PER_HOUR(6'h4)) uut (
    .mclk(mclk), .rst(rst), .ce(1'b1), .sleep_req(sleep_req), .standby_req(standby_req),
    .irq_any(irq_any), .ext_wake_line_a(ext_wake_line_a), .ext_wake_line_b(ext_wake_line_b),
    .transfer_done_event(transfer_done_event), .route_sel(route_sel),
    .adc_compare_match(adc_compare_match), .judgment_event(judgment_event),
    .judge_clear(judge_clear), .mode(mode), .cpu_halt(cpu_halt), .periph_run(periph_run),
    .snooze_periph_run(snooze_periph_run), .osc_run(osc_run), .state_hold(state_hold),
    .calendar_alarm_event(calendar_alarm_event), .adc_start_trig(adc_start_trig),
    .port_out_cmp(port_out_cmp), .port_out_judge(port_out_judge));

  transfer_ctrl_model partner (.mclk(mclk), .rst(rst), .mode(mode), .delay(delay),
    .transfer_done_event(transfer_done_event));

  initial forever #2.5 mclk = ~mclk;

  // Expected {cpu_halt, periph_run, snooze_periph_run, osc_run, state_hold}
  function automatic logic [4:0] outs(lpm_pkg::mode_t m);
    case (m)
      lpm_pkg::M_NORMAL: return 5'h0a;
      lpm_pkg::M_SLEEP: return 5'h1a;
      lpm_pkg::M_STANDBY: return 5'h11;
      default: return 5'h17;
    endcase
  endfunction : outs

  task automatic end_sim;
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // One-cycle request pulse; trailing edge keeps the next call off this time step
  task automatic req(input logic sl, input logic sb, input logic iq);
    sleep_req <= sl;
    standby_req <= sb;
    irq_any <= iq;
    @(posedge mclk);
    sleep_req <= 1'b0;
    standby_req <= 1'b0;
    irq_any <= 1'b0;
    @(posedge mclk);
  endtask : req

  // Bounded wait; a missed transition is caught by the leftover queue
  task automatic wait_mode(input lpm_pkg::mode_t m);
    for (int i = 0; i < 600 && mode !== m; i++) @(posedge mclk);
  endtask : wait_mode

  // Wake pin held until Normal is reached, then released low
  task automatic wake(input bit b);
    if (b) ext_wake_line_b <= 1'b1;
    else ext_wake_line_a <= 1'b1;
    wait_mode(lpm_pkg::M_NORMAL);
    ext_wake_line_a <= 1'b0;
    ext_wake_line_b <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : wake

  // Random compare, judgment and clear events, every cycle
  always @(posedge mclk) begin
    adc_compare_match <= ($random(seed) & 7) == 0;
    judgment_event <= ($random(seed) & 7) == 1;
    judge_clear <= ($random(seed) & 7) == 2;
  end

  // ****************************************************************
  // Output watcher
  // ****************************************************************
  always @(posedge mclk) begin
    if (rst) begin
      prev <= lpm_pkg::M_NORMAL;
      exp_cmp <= 1'b0;
      exp_judge <= 1'b0;
    end else begin
      cyc <= cyc + 1;
      `CHK({cpu_halt, periph_run, snooze_periph_run, osc_run, state_hold}, outs(mode))
      `CHK({port_out_cmp, port_out_judge}, {exp_cmp, exp_judge})
      exp_cmp <= adc_compare_match | (exp_cmp & ~judge_clear);
      exp_judge <= judgment_event | (exp_judge & ~judge_clear);
      if (mode !== prev) begin
        want = expq.size() > 0 ? expq.pop_front() : prev;
        `CHK(mode, want)
        prev <= mode;
      end
      // Spacing only judged when the router stayed on the timer between pulses
      if (adc_start_trig === 1'b1) begin
        if (last_trig >= 0 && !r0_seen) `CHK(cyc - last_trig, P)
        last_trig <= cyc;
        n_trig <= n_trig + 1;
        r0_seen <= 1'b0;
      end
      if (route_sel == 1'b0) r0_seen <= 1'b1;
      if (calendar_alarm_event === 1'b1) begin
        if (last_alm >= 0) `CHK(cyc - last_alm, P * HOUR)
        last_alm <= cyc;
      end
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK(mode, lpm_pkg::M_NORMAL)
    // Sleep left by the hourly alarm, which also aligns the hour
    expq.push_back(lpm_pkg::M_SLEEP);
    expq.push_back(lpm_pkg::M_NORMAL);
    req(1'b1, 1'b0, 1'b0);
    wait_mode(lpm_pkg::M_NORMAL);
    // Sleep left by any interrupt
    expq.push_back(lpm_pkg::M_SLEEP);
    expq.push_back(lpm_pkg::M_NORMAL);
    req(1'b1, 1'b0, 1'b0);
    req(1'b0, 1'b0, 1'b1);
    // Standby wins over sleep; underflow to Snooze starts the converter
    route_sel <= 1'b0;
    delay <= 8'h01 + 8'($random(seed) & 7);
    k = n_trig;
    expq.push_back(lpm_pkg::M_STANDBY);
    expq.push_back(lpm_pkg::M_SNOOZE);
    expq.push_back(lpm_pkg::M_STANDBY);
    req(1'b1, 1'b1, 1'b0);
    wait_mode(lpm_pkg::M_SNOOZE);
    repeat (2) @(posedge mclk);
    `CHK(n_trig - k, 1)
    route_sel <= 1'b1;
    wait_mode(lpm_pkg::M_STANDBY);
    // Slow transfer: wake line b ends Snooze first; mode requests ignored
    delay <= 8'h28;
    expq.push_back(lpm_pkg::M_SNOOZE);
    wait_mode(lpm_pkg::M_SNOOZE);
    expq.push_back(lpm_pkg::M_NORMAL);
    req(1'b1, 1'b1, 1'b0);
    wake(1'b1);
    // Standby ignores requests and interrupts, leaves on wake line a
    expq.push_back(lpm_pkg::M_STANDBY);
    expq.push_back(lpm_pkg::M_NORMAL);
    req(1'b0, 1'b1, 1'b0);
    req(1'b1, 1'b1, 1'b1);
    wake(1'b0);
    // Alarm ends the Snooze opened by the hour's last underflow
    delay <= 8'h05;
    expq.push_back(lpm_pkg::M_STANDBY);
    expq.push_back(lpm_pkg::M_SNOOZE);
    expq.push_back(lpm_pkg::M_STANDBY);
    expq.push_back(lpm_pkg::M_SNOOZE);
    expq.push_back(lpm_pkg::M_NORMAL);
    req(1'b0, 1'b1, 1'b0);
    wait_mode(lpm_pkg::M_NORMAL);
    // Normal run across two hours for timer and alarm spacing
    repeat (700) @(posedge mclk);
    `CHK(expq.size(), 0)
    end_sim();
  end

  // Watchdog well beyond the expected run of about 1200 cycles
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    end_sim();
  end
endmodule : low_power_mode_sequencer_tb_top
